/* File: design/mps_motion_selector.sv */
// Motion parameter selector: gain pick, speed derivation, servo-off timer, completion outputs
//
// Overview of operation
// - Three P/I velocity gain pairs are stored; exactly one pair drives the loop.
// - Schedule above 100 picks scheduled pair; else high-output flag picks pair.
// - Integral gain accepted from 1 to 99,999,999.
// - Torque filter constant accepted 0 to 2,500, presented to the loop.
// - Push speed is push velocity, or positioning speed when that is lower.
// - Per-entry push speed from the table replaces global push velocity if enabled.
// - Safety speed caps manual speed; range 1 to 250 or actuator max, default 100.
// - Power saving: selected 0..9,999 s delay from completion turns servo off.
// - Mode 0: completion output latched while servo is on.
// - Mode 1: completion output follows the position window.
// - Servo off forces the completion output low.
// - Completed position number follows the same latched or window behaviour.
// - Home sensor polarity: 0 unused, 1 normally open, 2 normally closed.
// - Home sensor change before mechanical end raises alarm 0BA.
// - Controller travel speed is table speed times override, 1..100 percent.
// - Override is not applied to tool-issued travel commands.
// - Jog select high uses second jog velocity, 1 to actuator max.
// - Direct numeric mode with jog select uses command speed unless it is zero.
// - Jog select low uses first jog velocity.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`default_nettype none
module mps_motion_selector
	import mps_pkg::*;
#(
	parameter int POS_BITS = 8,
	parameter int SEC_CYCLES = SEC_CYC
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Motion status from the driver core
	input  wire logic                servoOn,
	input  wire logic                moving,
	input  wire logic                posComplete,
	input  wire logic                inWindow,
	input  wire logic [POS_BITS-1:0] posNumber,
	input  wire logic                atMechEnd,
	input  wire logic                homing,
	input  wire logic                homeSensor,
	// Command inputs
	input  wire logic                pushMotion,
	input  wire logic [15:0]         tableSpeed,
	input  wire logic [15:0]         tablePushSpeed,
	input  wire logic                cmdFromTool,
	input  wire logic                jog_speed_select,
	input  wire logic                directMode,
	input  wire logic [15:0]         cmdSpeed,
	input  wire logic                safetySelect,
	input  wire logic [15:0]         manualSpeed,
	// Derived outputs
	output logic      [31:0]         activeGainP,
	output logic      [31:0]         activeGainI,
	output logic      [11:0]         torqueFilter,
	output logic      [15:0]         pushSpeed,
	output logic      [15:0]         travelSpeed,
	output logic      [15:0]         jogSpeed,
	output logic      [15:0]         manualLimited,
	output logic                     autoServoOff,
	output logic                     position_settled_latched,
	output logic      [POS_BITS-1:0] completed_position_bit,
	output logic                     homeAlarm,
	output logic      [11:0]         alarmCode
);
	if (POS_BITS < 1 || POS_BITS > 16) begin : g_bad_pos_bits
		$error("POS_BITS out of range");
	end
	if (SEC_CYCLES < 1) begin : g_bad_sec_cycles
		$error("SEC_CYCLES must be positive");
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, sched_q, trq_q, pushVel_q, safeVel_q, ovr_q;
	logic [31:0] jog1_q, jog2_q, maxSpd_q;
	logic [31:0] gainP_q [3];
	logic [31:0] gainI_q [3];
	logic [31:0] soffDly_q [3];
	logic        wr;
	logic [31:0] wmask;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	always_comb begin
		for (int b = 0; b < 4; b++) wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
	end

	// Merge byte lanes onto the current register value
	function automatic logic [31:0] merge(input logic [31:0] old);
		merge = (old & ~wmask) | (wb_dat_i & wmask);
	endfunction : merge

	always_ff @(posedge clock) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q    <= '0;
			sched_q   <= '0;
			trq_q     <= '0;
			pushVel_q <= VEL_RST;
			safeVel_q <= SAFEVEL_RST;
			ovr_q     <= OVR_MAX;
			jog1_q    <= VEL_RST;
			jog2_q    <= VEL_RST;
			maxSpd_q  <= MAXSPD_RST;
			for (int k = 0; k < 3; k++) begin
				gainP_q[k]   <= GAIN_RST;
				gainI_q[k]   <= GAIN_RST;
				soffDly_q[k] <= '0;
			end
		end else if (wr) begin
			// Writes outside range leave the register untouched
			if (wb_adr_i == OFS_CTRL) begin
				ctrl_q <= merge(ctrl_q) & 32'h0000_00FF;
			end else if (wb_adr_i == OFS_GSCHED) begin
				sched_q <= merge(sched_q);
			end else if (wb_adr_i == OFS_TRQFILT) begin
				if (merge(trq_q) <= TRQFILT_MAX) trq_q <= merge(trq_q);
			end else if (wb_adr_i == OFS_PUSHVEL) begin
				if (merge(pushVel_q) != '0 && merge(pushVel_q) <= maxSpd_q)
					pushVel_q <= merge(pushVel_q);
			end else if (wb_adr_i == OFS_SAFEVEL) begin
				if (merge(safeVel_q) != '0 && merge(safeVel_q) <= SAFEVEL_MAX
						&& merge(safeVel_q) <= maxSpd_q)
					safeVel_q <= merge(safeVel_q);
			end else if (wb_adr_i == OFS_OVERRIDE) begin
				if (merge(ovr_q) != '0 && merge(ovr_q) <= OVR_MAX)
					ovr_q <= merge(ovr_q);
			end else if (wb_adr_i == OFS_JOGVEL1) begin
				if (merge(jog1_q) != '0 && merge(jog1_q) <= maxSpd_q)
					jog1_q <= merge(jog1_q);
			end else if (wb_adr_i == OFS_JOGVEL2) begin
				if (merge(jog2_q) != '0 && merge(jog2_q) <= maxSpd_q)
					jog2_q <= merge(jog2_q);
			end else if (wb_adr_i == OFS_MAXSPD) begin
				if (merge(maxSpd_q) != '0 && merge(maxSpd_q) <= 32'h0000_FFFF)
					maxSpd_q <= merge(maxSpd_q);
			end else begin
				for (int k = 0; k < 3; k++) begin
					if (wb_adr_i == OFS_GAINP0 + 8'(4 * k)
							&& merge(gainP_q[k]) != '0 && merge(gainP_q[k]) <= GAIN_MAX)
						gainP_q[k] <= merge(gainP_q[k]);
					if (wb_adr_i == OFS_GAINI0 + 8'(4 * k)
							&& merge(gainI_q[k]) != '0 && merge(gainI_q[k]) <= GAIN_MAX)
						gainI_q[k] <= merge(gainI_q[k]);
					if (wb_adr_i == OFS_SOFFDLY0 + 8'(4 * k)
							&& merge(soffDly_q[k]) <= SOFFDLY_MAX)
						soffDly_q[k] <= merge(soffDly_q[k]);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Gain pair selection
	// ----------------------------------------------------------------
	logic [1:0] gainSel_d, gainSel_q;
	always_comb begin
		if (sched_q > SCHED_LIMIT) gainSel_d = 2'd1;
		else if (ctrl_q[CTRL_HIGHOUT]) gainSel_d = 2'd2;
		else gainSel_d = 2'd0;
	end
	always_ff @(posedge clock) begin
		if (rst) gainSel_q <= 2'd0;
		else if (!moving) gainSel_q <= gainSel_d;
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			activeGainP  <= GAIN_RST;
			activeGainI  <= GAIN_RST;
			torqueFilter <= '0;
		end else begin
			activeGainP  <= gainP_q[gainSel_q];
			activeGainI  <= gainI_q[gainSel_q];
			torqueFilter <= trq_q[11:0];
		end
	end

	// ----------------------------------------------------------------
	// Speed derivation
	// ----------------------------------------------------------------
	logic [15:0] pushBase;
	logic [31:0] ovrProd;
	assign pushBase = ctrl_q[CTRL_PUSHTBL] ? tablePushSpeed : pushVel_q[15:0];
	assign ovrProd  = tableSpeed * ovr_q[15:0];

	always_ff @(posedge clock) begin
		if (rst) begin
			pushSpeed     <= '0;
			travelSpeed   <= '0;
			jogSpeed      <= '0;
			manualLimited <= '0;
		end else begin
			if (pushMotion)
				pushSpeed <= (tableSpeed < pushBase) ? tableSpeed : pushBase;
			else
				pushSpeed <= '0;
			// Division by a constant; synthesises to a multiplier network
			travelSpeed <= cmdFromTool ? tableSpeed : 16'(ovrProd / OVR_MAX);
			if (!jog_speed_select) jogSpeed <= jog1_q[15:0];
			else if (directMode && cmdSpeed != '0) jogSpeed <= cmdSpeed;
			else jogSpeed <= jog2_q[15:0];
			manualLimited <= (safetySelect && manualSpeed > safeVel_q[15:0])
				? safeVel_q[15:0] : manualSpeed;
		end
	end

	// ----------------------------------------------------------------
	// Automatic servo-off timer
	// ----------------------------------------------------------------
	mps_sv_e     svState_q;
	logic [31:0] tick_q;
	logic [13:0] secs_q;
	logic [13:0] dlySel;
	assign dlySel = soffDly_q[(ctrl_q[CTRL_DLYSEL +: 2] == 2'd3) ? 2'd2
		: ctrl_q[CTRL_DLYSEL +: 2]][13:0];

	always_ff @(posedge clock) begin
		if (rst) begin
			svState_q    <= SV_IDLE;
			tick_q       <= '0;
			secs_q       <= '0;
			autoServoOff <= 1'b0;
		end else begin
			case (svState_q)
				SV_IDLE: begin
					autoServoOff <= 1'b0;
					tick_q       <= '0;
					secs_q       <= '0;
					if (ctrl_q[CTRL_SAVE_EN] && servoOn && posComplete && !moving)
						svState_q <= SV_COUNT;
				end
				SV_COUNT: begin
					if (!ctrl_q[CTRL_SAVE_EN] || moving || !servoOn) begin
						svState_q <= SV_IDLE;
					end else if (secs_q >= dlySel) begin
						svState_q    <= SV_OFF;
						autoServoOff <= 1'b1;
					end else if (tick_q == 32'(SEC_CYCLES - 1)) begin
						tick_q <= '0;
						secs_q <= secs_q + 14'd1;
					end else begin
						tick_q <= tick_q + 32'd1;
					end
				end
				default: begin
					// Held until a new move or clearing the power-saving enable clears it
					if (moving || !ctrl_q[CTRL_SAVE_EN]) begin
						svState_q    <= SV_IDLE;
						autoServoOff <= 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Completion outputs
	// ----------------------------------------------------------------
	logic latched_q;
	logic [POS_BITS-1:0] latchedNum_q;
	always_ff @(posedge clock) begin
		if (rst || !servoOn || moving) begin
			latched_q    <= 1'b0;
			latchedNum_q <= '0;
		end else if (posComplete && !latched_q) begin
			latched_q    <= 1'b1;
			latchedNum_q <= posNumber;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			position_settled_latched <= 1'b0;
			completed_position_bit   <= '0;
		end else if (!servoOn) begin
			position_settled_latched <= 1'b0;
			completed_position_bit   <= '0;
		end else if (!ctrl_q[CTRL_OUTMODE]) begin
			position_settled_latched <= latched_q;
			completed_position_bit   <= latchedNum_q;
		end else begin
			position_settled_latched <= latched_q && inWindow;
			completed_position_bit   <= (latched_q && inWindow) ? latchedNum_q : '0;
		end
	end

	// ----------------------------------------------------------------
	// Home confirmation sensor
	// ----------------------------------------------------------------
	logic    sensActive, sensPrev_q;
	mps_hs_e polar;
	assign polar = mps_hs_e'(ctrl_q[CTRL_POLAR +: 2]);
	always_comb begin
		case (polar)
			HS_NOPEN:   sensActive = homeSensor;
			HS_NCLOSED: sensActive = !homeSensor;
			default:    sensActive = 1'b0;
		endcase
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			sensPrev_q <= 1'b0;
			homeAlarm  <= 1'b0;
			alarmCode  <= '0;
		end else begin
			sensPrev_q <= sensActive;
			// Alarm is sticky until software rewrites CTRL
			if (homing && !atMechEnd && polar != HS_UNUSED && sensActive != sensPrev_q) begin
				homeAlarm <= 1'b1;
				alarmCode <= ALARM_HOME;
			end else if (wr && wb_adr_i == OFS_CTRL) begin
				homeAlarm <= 1'b0;
				alarmCode <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
			if (wb_adr_i == OFS_CTRL) wb_dat_o <= ctrl_q;
			else if (wb_adr_i == OFS_STATUS)
				wb_dat_o <= {16'h0, homeAlarm, autoServoOff, position_settled_latched,
					11'h0, gainSel_q};
			else if (wb_adr_i == OFS_GSCHED) wb_dat_o <= sched_q;
			else if (wb_adr_i == OFS_TRQFILT) wb_dat_o <= trq_q;
			else if (wb_adr_i == OFS_PUSHVEL) wb_dat_o <= pushVel_q;
			else if (wb_adr_i == OFS_SAFEVEL) wb_dat_o <= safeVel_q;
			else if (wb_adr_i == OFS_OVERRIDE) wb_dat_o <= ovr_q;
			else if (wb_adr_i == OFS_JOGVEL1) wb_dat_o <= jog1_q;
			else if (wb_adr_i == OFS_JOGVEL2) wb_dat_o <= jog2_q;
			else if (wb_adr_i == OFS_MAXSPD) wb_dat_o <= maxSpd_q;
			else if (wb_adr_i == OFS_ACTGAINP) wb_dat_o <= activeGainP;
			else if (wb_adr_i == OFS_ACTGAINI) wb_dat_o <= activeGainI;
			else if (wb_adr_i >= OFS_GAINP0 && wb_adr_i < OFS_GAINI0)
				wb_dat_o <= gainP_q[2'((wb_adr_i - OFS_GAINP0) >> 2)];
			else if (wb_adr_i >= OFS_GAINI0 && wb_adr_i < OFS_TRQFILT)
				wb_dat_o <= gainI_q[2'((wb_adr_i - OFS_GAINI0) >> 2)];
			else if (wb_adr_i >= OFS_SOFFDLY0 && wb_adr_i < OFS_OVERRIDE)
				wb_dat_o <= soffDly_q[2'((wb_adr_i - OFS_SOFFDLY0) >> 2)];
			else wb_dat_o <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_SERVO_OFF_CLEARS: assert property (@(posedge clock) disable iff (rst)
		!servoOn |=> !position_settled_latched && completed_position_bit == '0)
		else $error("completion output high with servo off");
	AST_WINDOW_MODE: assert property (@(posedge clock) disable iff (rst)
		position_settled_latched && ctrl_q[CTRL_OUTMODE] && $stable(ctrl_q) |-> $past(inWindow))
		else $error("window mode output outside window");
	AST_GAIN_HOLD: assert property (@(posedge clock) disable iff (rst)
		moving && $past(moving) |-> $stable(gainSel_q))
		else $error("gain pair changed during move");
	AST_SCHED_PICK: assert property (@(posedge clock) disable iff (rst)
		!moving && sched_q > SCHED_LIMIT |=> gainSel_q == 2'd1)
		else $error("scheduled pair not chosen");
	AST_PUSH_MIN: assert property (@(posedge clock) disable iff (rst)
		pushMotion |=> pushSpeed <= $past(pushBase) && pushSpeed <= $past(tableSpeed))
		else $error("push speed above limit");
	AST_JOG_SEL: assert property (@(posedge clock) disable iff (rst)
		!jog_speed_select |=> jogSpeed == $past(jog1_q[15:0]))
		else $error("jog speed not first velocity");
	AST_TOOL_NO_OVR: assert property (@(posedge clock) disable iff (rst)
		cmdFromTool |=> travelSpeed == $past(tableSpeed))
		else $error("override applied to tool command");
	AST_OVR_RANGE: assert property (@(posedge clock) disable iff (rst)
		ovr_q != '0 && ovr_q <= OVR_MAX)
		else $error("override outside 1 to 100");
	AST_SAFE_CAP: assert property (@(posedge clock) disable iff (rst)
		safetySelect |=> manualLimited <= $past(safeVel_q[15:0]))
		else $error("manual speed exceeds safety velocity");
	AST_HOME_ALARM: assert property (@(posedge clock) disable iff (rst)
		homeAlarm |-> alarmCode == ALARM_HOME)
		else $error("home alarm without code");
	COV_AUTO_OFF: cover property (@(posedge clock) disable iff (rst) $rose(autoServoOff));
	COV_HOME_ALARM: cover property (@(posedge clock) disable iff (rst) $rose(homeAlarm));
	COV_WINDOW_DROP: cover property (@(posedge clock) disable iff (rst)
		ctrl_q[CTRL_OUTMODE] && $fell(position_settled_latched) && servoOn);
endmodule : mps_motion_selector
`default_nettype wire

/* File: design/mps_pkg.sv */
// Package: register map, field layout, reset values and constants of the parameter selector
`default_nettype none
package mps_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_GSCHED   = 8'h08;
	localparam logic [7:0] OFS_GAINP0   = 8'h0C;
	localparam logic [7:0] OFS_GAINI0   = 8'h18;
	localparam logic [7:0] OFS_TRQFILT  = 8'h24;
	localparam logic [7:0] OFS_PUSHVEL  = 8'h28;
	localparam logic [7:0] OFS_SAFEVEL  = 8'h2C;
	localparam logic [7:0] OFS_SOFFDLY0 = 8'h30;
	localparam logic [7:0] OFS_OVERRIDE = 8'h3C;
	localparam logic [7:0] OFS_JOGVEL1  = 8'h40;
	localparam logic [7:0] OFS_JOGVEL2  = 8'h44;
	localparam logic [7:0] OFS_MAXSPD   = 8'h48;
	localparam logic [7:0] OFS_ACTGAINP = 8'h4C;
	localparam logic [7:0] OFS_ACTGAINI = 8'h50;
	// ----------------------------------------------------------------
	// CTRL field positions
	// ----------------------------------------------------------------
	localparam int CTRL_HIGHOUT  = 0;
	localparam int CTRL_OUTMODE  = 1;
	localparam int CTRL_SAVE_EN  = 2;
	localparam int CTRL_DLYSEL   = 3;
	localparam int CTRL_POLAR    = 5;
	localparam int CTRL_PUSHTBL  = 7;
	// ----------------------------------------------------------------
	// Ranges and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] GAIN_MAX     = 32'h05F5_E0FF;
	localparam logic [31:0] GAIN_RST     = 32'h0000_0001;
	localparam logic [31:0] TRQFILT_MAX  = 32'h0000_09C4;
	localparam logic [31:0] SAFEVEL_MAX  = 32'h0000_00FA;
	localparam logic [31:0] SAFEVEL_RST  = 32'h0000_0064;
	localparam logic [31:0] SOFFDLY_MAX  = 32'h0000_270F;
	localparam logic [31:0] OVR_MAX      = 32'h0000_0064;
	localparam logic [31:0] SCHED_LIMIT  = 32'h0000_0064;
	localparam logic [31:0] MAXSPD_RST   = 32'h0000_01F4;
	localparam logic [31:0] VEL_RST      = 32'h0000_0064;
	localparam logic [11:0] ALARM_HOME   = 12'h0BA;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ  = 50_000_000;
	localparam int SEC_S   = 1;
	localparam int SEC_CYC = CLK_HZ * SEC_S;
	// Home sensor polarity
	typedef enum logic [1:0] {HS_UNUSED, HS_NOPEN, HS_NCLOSED, HS_RSVD} mps_hs_e;
	typedef enum {SV_IDLE, SV_COUNT, SV_OFF} mps_sv_e;
endpackage : mps_pkg
`default_nettype wire

/* File: testbench/mps_plc_model.sv */
// Controller model that issues travel, push and jog commands to the selector
`default_nettype none
module mps_plc_model (
	// Clock
	input  wire logic   clock,
	// Command outputs
	output logic        pushMotion,
	output logic        cmdFromTool,
	output logic        jogSel,
	output logic        directMode,
	output logic [15:0] tableSpeed,
	output logic [15:0] tablePushSpeed,
	output logic [15:0] cmdSpeed
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pushMotion = 1'b0;
		cmdFromTool = 1'b0;
		jogSel = 1'b0;
		directMode = 1'b0;
		tableSpeed = 16'h0000;
		tablePushSpeed = 16'h0000;
		cmdSpeed = 16'h0000;
	end
	// Whole command changes on one edge, like a scanned output image
	task automatic issue(input logic p, t, j, d, input logic [15:0] s, ps, cs);
		@(posedge clock);
		pushMotion <= p;
		cmdFromTool <= t;
		jogSel <= j;
		directMode <= d;
		tableSpeed <= s;
		tablePushSpeed <= ps;
		cmdSpeed <= cs;
	endtask : issue
endmodule : mps_plc_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the motion parameter selector
`default_nettype none
module tb_top import mps_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [3:0]  wbSel = 4'h0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDatI = 32'h0;
	logic        servoOn = 1'b0, moving = 1'b0, posDone = 1'b0, inWin = 1'b0;
	logic        mechEnd = 1'b0, homing = 1'b0, homeSens = 1'b0, safeSel = 1'b0;
	logic [7:0]  posNum = 8'h00;
	logic [15:0] manSpd = 16'h0000;
	logic [31:0] wbDatO, rdData, gainP, gainI;
	logic        wbAck, push, tool, jogSel, direct, setl, aso, hAlarm;
	logic [15:0] tblSpd, tblPush, cmdSpd, pushSpd, travSpd, jogSpd, manLim;
	logic [11:0] trq, alCode;
	logic [7:0]  donePos;
	int          errCount = 0;
	int          compares = 0;
	// Jog rows: select, direct mode, command speed, expected jog speed
	localparam logic [33:0] JOG_ROWS [4] = '{{2'b00, 16'h0000, 16'h0064},
		{2'b10, 16'h0032, 16'h00C8}, {2'b11, 16'h0000, 16'h00C8}, {2'b11, 16'h0032, 16'h0032}};
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	mps_motion_selector #(.POS_BITS(8), .SEC_CYCLES(4)) mps_motion_selector_i (
		.clock(clock), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .servoOn(servoOn), .moving(moving), .posComplete(posDone),
		.inWindow(inWin), .posNumber(posNum), .atMechEnd(mechEnd), .homing(homing),
		.homeSensor(homeSens), .pushMotion(push), .tableSpeed(tblSpd),
		.tablePushSpeed(tblPush), .cmdFromTool(tool), .jog_speed_select(jogSel),
		.directMode(direct), .cmdSpeed(cmdSpd), .safetySelect(safeSel),
		.manualSpeed(manSpd), .activeGainP(gainP), .activeGainI(gainI),
		.torqueFilter(trq), .pushSpeed(pushSpd), .travelSpeed(travSpd), .jogSpeed(jogSpd),
		.manualLimited(manLim), .autoServoOff(aso), .position_settled_latched(setl),
		.completed_position_bit(donePos), .homeAlarm(hAlarm), .alarmCode(alCode));
	mps_plc_model mps_plc_model_i (.clock(clock), .pushMotion(push), .cmdFromTool(tool),
		.jogSel(jogSel), .directMode(direct), .tableSpeed(tblSpd),
		.tablePushSpeed(tblPush), .cmdSpeed(cmdSpd));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		wbSel <= s;
		do begin
			@(posedge clock);
			n++;
		end while (wbAck !== 1'b1 && n < 40);
		if (n >= 40) errCount++;
		rdData = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask : rd
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
	endtask : tick
	task automatic results();
		$display("compares %0d errors %0d", compares, errCount);
		if (errCount == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		errCount++;
		results();
	end
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		tick(1);
		chk("gainP", gainP, GAIN_RST);
		rd(8'h60);
		chk("unmapped", rdData, 32'h0);
		rd(OFS_SAFEVEL);
		chk("safety", rdData, SAFEVEL_RST);
		// Only byte lane 0 may land; upper garbage must not trip the range check
		bus(1'b1, OFS_OVERRIDE, 32'hFFFF_FF14, 4'h1);
		wr(OFS_OVERRIDE, 32'h0);
		wr(OFS_OVERRIDE, 32'h65);
		rd(OFS_OVERRIDE);
		chk("override", rdData, 32'h14);
		mps_plc_model_i.issue(1'b0, 1'b0, 1'b0, 1'b0, 16'h01F4, 16'h0, 16'h0);
		tick(3);
		chk("travel", travSpd, 16'h0064);
		mps_plc_model_i.issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h01F4, 16'h0, 16'h0);
		tick(3);
		chk("toolTravel", travSpd, 16'h01F4);
		wr(OFS_JOGVEL2, 32'hC8);
		foreach (JOG_ROWS[i]) begin
			mps_plc_model_i.issue(1'b0, 1'b0, JOG_ROWS[i][33], JOG_ROWS[i][32], 16'h0, 16'h0,
				JOG_ROWS[i][31:16]);
			tick(3);
			chk("jog", jogSpd, JOG_ROWS[i][15:0]);
		end
		wr(OFS_PUSHVEL, 32'h32);
		mps_plc_model_i.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h001E, 16'h0046, 16'h0);
		tick(3);
		chk("pushSlow", pushSpd, 16'h001E);
		mps_plc_model_i.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h0050, 16'h0046, 16'h0);
		tick(3);
		chk("push", pushSpd, 16'h0032);
		wr(OFS_CTRL, 32'h80);
		tick(3);
		chk("pushTable", pushSpd, 16'h0046);
		safeSel <= 1'b1;
		manSpd <= 16'h00C8;
		wr(OFS_SAFEVEL, 32'hFB);
		tick(3);
		chk("manLimit", manLim, 16'h0064);
		wr(OFS_SAFEVEL, 32'hFA);
		tick(3);
		chk("manFree", manLim, 16'h00C8);
		wr(OFS_TRQFILT, 32'h9C4);
		wr(OFS_TRQFILT, 32'h9C5);
		tick(3);
		chk("trq", trq, 12'h9C4);
		wr(8'h0C, 32'h7);
		wr(8'h10, 32'h9);
		wr(8'h14, 32'hB);
		wr(OFS_GAINI0, 32'h0);
		wr(OFS_CTRL, 32'h0);
		tick(3);
		chk("gainBase", gainP, 32'h7);
		chk("gainI", gainI, GAIN_RST);
		wr(OFS_CTRL, 32'h1);
		tick(3);
		chk("gainHigh", gainP, 32'hB);
		wr(OFS_GSCHED, 32'h65);
		tick(3);
		chk("gainSched", gainP, 32'h9);
		wr(OFS_GSCHED, 32'h64);
		tick(3);
		chk("gain100", gainP, 32'hB);
		moving <= 1'b1;
		wr(OFS_CTRL, 32'h0);
		tick(3);
		chk("gainHold", gainP, 32'hB);
		moving <= 1'b0;
		tick(3);
		chk("gainStop", gainP, 32'h7);
		servoOn <= 1'b1;
		posNum <= 8'h05;
		posDone <= 1'b1;
		tick(1);
		posDone <= 1'b0;
		tick(3);
		chk("latched", setl, 1'b1);
		chk("donePos", donePos, 8'h05);
		wr(OFS_CTRL, 32'h2);
		tick(3);
		chk("winOut", setl, 1'b0);
		inWin <= 1'b1;
		tick(3);
		chk("winIn", setl, 1'b1);
		chk("winPos", donePos, 8'h05);
		servoOn <= 1'b0;
		tick(3);
		chk("servoOff", setl, 1'b0);
		// Completion held as a level so the timer can start once saving is on
		servoOn <= 1'b1;
		posDone <= 1'b1;
		wr(OFS_SOFFDLY0, 32'h2);
		wr(OFS_SOFFDLY0, 32'h2710);
		wr(OFS_CTRL, 32'h4);
		tick(3);
		chk("asoEarly", aso, 1'b0);
		for (int i = 0; i < 40 && aso !== 1'b1; i++) @(posedge clock);
		chk("asoLate", aso, 1'b1);
		moving <= 1'b1;
		posDone <= 1'b0;
		tick(3);
		chk("asoMove", aso, 1'b0);
		moving <= 1'b0;
		homing <= 1'b1;
		for (int p = 0; p < 3; p++) begin
			wr(OFS_CTRL, 32'(p) << CTRL_POLAR);
			homeSens <= ~homeSens;
			tick(3);
			chk("homeAlarm", hAlarm, p != 0);
			if (p != 0) chk("alarmCode", alCode, ALARM_HOME);
		end
		// Mechanical end first, so the polarity switch itself cannot alarm
		mechEnd <= 1'b1;
		wr(OFS_CTRL, 32'h20);
		homeSens <= ~homeSens;
		tick(3);
		chk("homeAtEnd", hAlarm, 1'b0);
		// Reset in mid-run restores defaults
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(1);
		chk("rstGain", gainP, GAIN_RST);
		rd(OFS_OVERRIDE);
		chk("rstOvr", rdData, OVR_MAX);
		results();
	end
endmodule : tb_top
`default_nettype wire
